// File: core/tsf_map.svh
// Purpose: register offsets, field positions, reset values and timing
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes:   definitions only; shared by the tag filter top and its bench
`ifndef TSF_MAP_SVH
`define TSF_MAP_SVH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define TSF_OFF_CTRL    8'h00
`define TSF_OFF_SESS    8'h04
`define TSF_OFF_FMODE   8'h08
`define TSF_OFF_FLT0    8'h0C
`define TSF_OFF_FDAT0   8'h10
`define TSF_OFF_FLT1    8'h14
`define TSF_OFF_FDAT1   8'h18
`define TSF_OFF_SMOOTH  8'h1C
`define TSF_OFF_EWL     8'h20
`define TSF_OFF_PERIOD  8'h24
`define TSF_OFF_STATUS  8'h28
`define TSF_OFF_RSP     8'h2C
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TSF_CTRL_START  0
`define TSF_CTRL_STOP   1
`define TSF_CTRL_REP    2
`define TSF_SESS_SEL    0
`define TSF_SESS_DEF    2
`define TSF_SM_DUP      0
`define TSF_SM_RRD      1
`define TSF_SM_OMIT     2
`define TSF_FLT_BANK    0
`define TSF_FLT_ADDR    8
`define TSF_FLT_LEN     16
`define TSF_STAT_RUN    0
`define TSF_STAT_NEMPTY 1
`define TSF_STAT_SUM    2
`define TSF_STAT_CNT    8
`define TSF_REC_KIND    30
`define TSF_REC_EWL     24
`define TSF_REC_CNT     16
// ----------------------------------------------------------------------
// reset values and length limit
// ----------------------------------------------------------------------
`define TSF_RST_SESS_DEF 1'b1
`define TSF_RST_EWL      6'h00
`define TSF_RST_PERIOD   16'h0000
`define TSF_EWL_MAX      6'h20
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TSF_CLK_NS     4
`define TSF_MS_NS      1000000
`define TSF_S1_MIN_MS  500
`define TSF_S1_MAX_MS  5000
`define TSF_S23_MS     2000
`endif

// File: core/tsf_pkg.sv
// Purpose: shared types of the tag session and filter control
// Assumes: nothing beyond the map header
// Notes:   encodings written out so the register image is fixed
package tsf_pkg;
  typedef enum logic [1:0] {
    TSF_S0 = 2'b00, TSF_S1 = 2'b01, TSF_S2 = 2'b10, TSF_S3 = 2'b11
  } tsf_sess_t;
  typedef enum logic [1:0] {
    TSF_F_FIRST = 2'b00, TSF_F_SECOND = 2'b01,
    TSF_F_AND   = 2'b10, TSF_F_OR     = 2'b11
  } tsf_fmode_t;
  typedef enum logic [1:0] {
    TSF_IDLE = 2'b00, TSF_RUN = 2'b01, TSF_SUM = 2'b10
  } tsf_state_t;
  typedef enum logic [1:0] {
    TSF_K_TAG = 2'b01, TSF_K_SUM = 2'b10
  } tsf_kind_t;
endpackage : tsf_pkg

// File: core/tsf_fifo_if.sv
// Purpose: valid/ready carrier between the control top and its fifo
// Assumes: single clock
// Notes:   fifo modport is the buffer, user modport is the control logic
`timescale 1ns/100ps
`default_nettype none
interface tsf_fifo_if #(parameter int W = 32);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data);
endinterface : tsf_fifo_if
`default_nettype wire

// File: core/tsf_fifo.sv
// Purpose: response record buffer between tag engine and register reads
// Assumes: DEPTH a power of two, at least 2
// Notes:   full shows as in_ready low; no overwrite ever happens
`timescale 1ns/100ps
`default_nettype none
module tsf_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input wire logic  clk,
  input wire logic  rst_n,
  tsf_fifo_if.fifo  f
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("tsf_fifo: DEPTH must be a power of two");
  end
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire push = f.in_valid & f.in_ready;
  wire pop  = f.out_valid & f.out_ready;
  // ----------------------------------------------------------------------
  // flags and read port
  // ----------------------------------------------------------------------
  assign f.in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_q != '0);
  assign f.out_data  = mem_q[rp_q];
  // storage needs no reset, only slots below the count are ever read
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q] <= f.in_data;
  end
  // pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : tsf_fifo
`default_nettype wire

// File: core/tsf_ctrl.sv
// Purpose: tag session, filter, smoothing and EPC length control
// Assumes: tag reports arrive synchronous to pclk, one per handshake
// Notes:   responses are drained by reading the response register
//
// Overview of operation
// - default S0 once, S2 repeat
// - S0 once: talk to every tag
// - S1 to S3 once: skip inventoried tags
// - S1 flag reverts after fixed persistence
// - S2/S3 revert only after absence
// - S2 repeat: only newly detected tags
// - S3 repeat behaves like S2
// - S0 repeat reads conflicting flagged tags
// - two stored filter conditions gate tags
// - filter modes first, second, and, or
// - no duplicate identifier per response
// - repeat: read tag silent during sequence
// - repeat: omit empty period response
// - length 0 auto, 1..32 fixed
// - auto mode uses measured tag length
`timescale 1ns/100ps
`default_nettype none
`include "tsf_map.svh"
module tsf_ctrl
  import tsf_pkg::*;
#(
  parameter int ID_W   = 16,
  parameter int MEM_W  = 64,
  parameter int N_ENT  = 8,
  parameter int FIFO_D = 8,
  parameter int MS_CYC = `TSF_MS_NS / `TSF_CLK_NS,
  parameter int S1_MS  = `TSF_S1_MIN_MS,
  parameter int S23_MS = `TSF_S23_MS
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output var  logic [31:0]        prdata,
  output var  logic               pready,
  output var  logic               pslverr,
  input  wire logic               tag_valid,
  output var  logic               tag_ready,
  input  wire logic [ID_W-1:0]    tag_id,
  input  wire logic [5:0]         tag_ewl,
  input  wire logic [4*MEM_W-1:0] tag_mem
);
  localparam int IW = $clog2(N_ENT);
  localparam int TW = $clog2(MS_CYC + 1);
  if (ID_W > 16 || MEM_W < 32 || MEM_W > 64 || N_ENT < 2 ||
      MS_CYC < 1 || S1_MS < `TSF_S1_MIN_MS || S1_MS > `TSF_S1_MAX_MS ||
      S23_MS < 1 || S23_MS > 8190) begin : g_chk
    $error("tsf_ctrl: unsupported parameter value");
  end

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  // bitwise filter test; running past the bank end is a mismatch
  function automatic logic flt_hit(input logic [MEM_W-1:0] mem,
                                   input logic [5:0] addr,
                                   input logic [5:0] len,
                                   input logic [31:0] dat);
    logic       ok;
    logic [6:0] p;
    ok = 1'b1;
    for (int i = 0; i < 32; i++) begin
      p = 7'(addr) + 7'(i);
      if (i < int'(len)) begin
        if (int'(p) >= MEM_W) ok = 1'b0;
        else if (mem[MEM_W-1-int'(p)] != dat[31-i]) ok = 1'b0;
      end
    end
    return ok;
  endfunction : flt_hit
  // index of the lowest set bit
  function automatic logic [IW-1:0] pick(input logic [N_ENT-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int i = N_ENT - 1; i >= 0; i--) begin
      if (v[i]) r = IW'(i);
    end
    return r;
  endfunction : pick

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  tsf_state_t    st_q;
  tsf_sess_t     sess_q;
  tsf_fmode_t    fmode_q;
  logic          sess_def_q, rep_q, dup_q, rrd_q, omit_q;
  logic [21:0]   flt_q [2];
  logic [31:0]   fdat_q [2];
  logic [5:0]    ewl_q;
  logic [15:0]   period_q, per_cnt_q;
  logic [7:0]    cnt_q;
  logic [TW-1:0] tick_q;
  logic          in_v_q, tag_rdy_q;
  logic [ID_W-1:0]    in_id_q;
  logic [5:0]         in_ewl_q;
  logic [4*MEM_W-1:0] in_mem_q;
  logic [N_ENT-1:0]   ev_q, er_q;
  logic [ID_W-1:0]    eid_q [N_ENT];
  logic [12:0]        eage_q [N_ENT];
  logic [IW-1:0]      rr_q;
  logic [31:0]        prdata_q;
  logic               pready_q, pslverr_q;
  tsf_fifo_if #(.W(32)) rq ();

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  // one wait state so read data and error both leave from flops
  wire acc    = psel & penable & ~pready_q;
  wire commit = psel & penable & pready_q;
  wire wr     = commit & pwrite;
  wire s_ctrl = (paddr == `TSF_OFF_CTRL);
  wire s_sess = (paddr == `TSF_OFF_SESS);
  wire s_fm   = (paddr == `TSF_OFF_FMODE);
  wire s_f0   = (paddr == `TSF_OFF_FLT0);
  wire s_d0   = (paddr == `TSF_OFF_FDAT0);
  wire s_f1   = (paddr == `TSF_OFF_FLT1);
  wire s_d1   = (paddr == `TSF_OFF_FDAT1);
  wire s_sm   = (paddr == `TSF_OFF_SMOOTH);
  wire s_ewl  = (paddr == `TSF_OFF_EWL);
  wire s_per  = (paddr == `TSF_OFF_PERIOD);
  wire s_stat = (paddr == `TSF_OFF_STATUS);
  wire s_rsp  = (paddr == `TSF_OFF_RSP);
  wire mapped = s_ctrl | s_sess | s_fm | s_f0 | s_d0 | s_f1 | s_d1 |
                s_sm | s_ewl | s_per | s_stat | s_rsp;
  wire ewl_ok = (pwdata[31:6] == 26'h0) & (pwdata[5:0] <= `TSF_EWL_MAX);
  wire bad    = ~mapped | (pwrite & s_ewl & ~ewl_ok);
  wire go     = wr & s_ctrl & pwdata[`TSF_CTRL_START] & (st_q == TSF_IDLE);
  wire stop   = wr & s_ctrl & pwdata[`TSF_CTRL_STOP];
  // reading the response register pops one record; a read that found
  // the buffer empty returned zero and must not pop a later arrival
  wire pop    = commit & ~pwrite & s_rsp & rq.out_valid &
                (prdata_q[`TSF_REC_KIND +: 2] != 2'b00);
  wire [31:0] stat_w = (32'(cnt_q) << `TSF_STAT_CNT) |
                       (32'(st_q == TSF_SUM) << `TSF_STAT_SUM) |
                       (32'(rq.out_valid) << `TSF_STAT_NEMPTY) |
                       (32'(st_q != TSF_IDLE) << `TSF_STAT_RUN);
  wire [31:0] rd_w =
    s_ctrl ? (32'(rep_q) << `TSF_CTRL_REP) :
    s_sess ? (32'(sess_def_q) << `TSF_SESS_DEF) | 32'(sess_q) :
    s_fm   ? 32'(fmode_q) :
    s_f0   ? 32'(flt_q[0]) :
    s_d0   ? fdat_q[0] :
    s_f1   ? 32'(flt_q[1]) :
    s_d1   ? fdat_q[1] :
    s_sm   ? 32'({omit_q, rrd_q, dup_q}) :
    s_ewl  ? 32'(ewl_q) :
    s_per  ? 32'(period_q) :
    s_stat ? stat_w :
    (s_rsp & rq.out_valid) ? rq.out_data : 32'h0000_0000;

  // bus answer flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q <= acc;
      if (acc) pslverr_q <= bad;
      if (acc) prdata_q <= rd_w;
    end
  end

  // configuration registers; a refused write leaves the value alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rep_q <= 1'b0;  sess_def_q <= `TSF_RST_SESS_DEF;  sess_q <= TSF_S0;
      fmode_q <= TSF_F_FIRST;  dup_q <= 1'b0;  rrd_q <= 1'b0;
      omit_q <= 1'b0;  ewl_q <= `TSF_RST_EWL;  period_q <= `TSF_RST_PERIOD;
      flt_q[0] <= '0;  flt_q[1] <= '0;
      fdat_q[0] <= '0;  fdat_q[1] <= '0;
    end else if (wr) begin
      if (s_ctrl) rep_q <= pwdata[`TSF_CTRL_REP];
      if (s_sess) sess_def_q <= pwdata[`TSF_SESS_DEF];
      if (s_sess) sess_q <= tsf_sess_t'(pwdata[`TSF_SESS_SEL +: 2]);
      if (s_fm) fmode_q <= tsf_fmode_t'(pwdata[1:0]);
      if (s_f0) flt_q[0] <= pwdata[21:0];
      if (s_f1) flt_q[1] <= pwdata[21:0];
      if (s_d0) fdat_q[0] <= pwdata;
      if (s_d1) fdat_q[1] <= pwdata;
      if (s_sm) {omit_q, rrd_q, dup_q} <= pwdata[2:0];
      if (s_ewl && ewl_ok) ewl_q <= pwdata[5:0];
      if (s_per) period_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // session and filter decisions
  // ----------------------------------------------------------------------
  // session default
  wire tsf_sess_t eff_s = sess_def_q ? (rep_q ? TSF_S2 : TSF_S0) : sess_q;
  wire s1   = (eff_s == TSF_S1);
  wire s23  = (eff_s == TSF_S2) | (eff_s == TSF_S3);
  wire [N_ENT-1:0] hv;
  for (genvar i = 0; i < N_ENT; i++) begin : g_hit
    assign hv[i] = ev_q[i] & (eid_q[i] == in_id_q);
  end
  wire          any_hit = |hv;
  wire [IW-1:0] hit_i   = pick(hv);
  wire [1:0] b0 = flt_q[0][`TSF_FLT_BANK +: 2];
  wire [1:0] b1 = flt_q[1][`TSF_FLT_BANK +: 2];
  wire f0 = flt_hit(in_mem_q[int'(b0)*MEM_W +: MEM_W],
                    flt_q[0][`TSF_FLT_ADDR +: 6],
                    flt_q[0][`TSF_FLT_LEN +: 6], fdat_q[0]);
  wire f1 = flt_hit(in_mem_q[int'(b1)*MEM_W +: MEM_W],
                    flt_q[1][`TSF_FLT_ADDR +: 6],
                    flt_q[1][`TSF_FLT_LEN +: 6], fdat_q[1]);
  wire pass = (fmode_q == TSF_F_FIRST)  ? f0 :
              (fmode_q == TSF_F_SECOND) ? f1 :
              (fmode_q == TSF_F_AND)    ? (f0 & f1) : (f0 | f1);
  // S1 to S3 skip read tags
  wire blk  = (eff_s != TSF_S0) & any_hit;
  wire dup  = dup_q & any_hit & er_q[hit_i];
  wire rrd  = rrd_q & rep_q & any_hit;
  wire accept  = (st_q == TSF_RUN) & pass & ~blk & ~dup & ~rrd;
  wire want    = in_v_q & accept;
  wire push_tg = want & rq.in_ready;
  // tags wait while a summary owns the fifo, and stall on a full fifo
  wire consume = in_v_q & (st_q != TSF_SUM) & (~accept | rq.in_ready);
  wire alloc   = push_tg & ~any_hit;
  wire [IW-1:0] victim = (&ev_q) ? rr_q : pick(~ev_q);

  // ----------------------------------------------------------------------
  // period timing and omission
  // ----------------------------------------------------------------------
  wire ms_tick = (tick_q == TW'(MS_CYC - 1));
  wire per_wrap = (st_q == TSF_RUN) & ms_tick & (period_q != 16'h0000) &
                  (per_cnt_q == period_q - 16'h0001);
  wire skip  = rep_q & omit_q & (cnt_q == 8'h00) & ~push_tg;
  wire sum_done = (st_q == TSF_SUM) & rq.in_ready;
  wire clr   = go | (per_wrap & skip) | sum_done;
  // flags keep living while a re-read guarded sequence runs
  wire hold  = rrd_q & rep_q & (st_q != TSF_IDLE);
  wire [12:0] lim = s1 ? 13'(S1_MS) : 13'(S23_MS);

  // millisecond prescaler runs always so flags age while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tick_q <= '0;
    else tick_q <= ms_tick ? '0 : tick_q + 1'b1;
  end

  // period counter and per-period tag count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_q <= 16'h0000;
      cnt_q     <= 8'h00;
    end else begin
      if (go || per_wrap) per_cnt_q <= 16'h0000;
      else if (ms_tick && st_q == TSF_RUN) per_cnt_q <= per_cnt_q + 1'b1;
      if (clr) cnt_q <= 8'h00;
      else if (push_tg && cnt_q != 8'hFF) cnt_q <= cnt_q + 1'b1;
    end
  end

  // sequence state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= TSF_IDLE;
    else begin
      case (st_q)
        TSF_IDLE: if (go) st_q <= TSF_RUN;
        TSF_RUN: begin
          if (stop) st_q <= TSF_IDLE;
          else if (per_wrap && !skip) st_q <= TSF_SUM;
        end
        TSF_SUM: begin
          if (stop) st_q <= TSF_IDLE;
          else if (rq.in_ready) st_q <= rep_q ? TSF_RUN : TSF_IDLE;
        end
        default: st_q <= TSF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // tag input latch
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_v_q <= 1'b0;  tag_rdy_q <= 1'b1;
      in_id_q <= '0;  in_ewl_q <= 6'h00;  in_mem_q <= '0;
    end else if (tag_valid && tag_rdy_q) begin
      in_v_q <= 1'b1;  tag_rdy_q <= 1'b0;
      in_id_q <= tag_id;  in_ewl_q <= tag_ewl;  in_mem_q <= tag_mem;
    end else if (consume) begin
      in_v_q <= 1'b0;  tag_rdy_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // inventoried tag table
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < N_ENT; i++) begin : g_ent
    wire mine = alloc & (victim == IW'(i));
    wire expire = ms_tick & ev_q[i] & ~hold & (eage_q[i] >= lim);
    wire rfsh   = consume & hv[i] & s23;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ev_q[i] <= 1'b0;  er_q[i] <= 1'b0;
        eid_q[i] <= '0;  eage_q[i] <= 13'h0000;
      end else if (mine) begin
        ev_q[i] <= 1'b1;  er_q[i] <= 1'b1;
        eid_q[i] <= in_id_q;  eage_q[i] <= 13'h0000;
      end else begin
        if (expire) ev_q[i] <= 1'b0;
        if (rfsh) eage_q[i] <= 13'h0000;
        else if (ms_tick && eage_q[i] != 13'h1FFF) eage_q[i] <= eage_q[i] + 1'b1;
        // a report in the clearing cycle keeps its mark
        if (push_tg && hv[i]) er_q[i] <= 1'b1;
        else if (clr) er_q[i] <= 1'b0;
      end
    end
  end
  // replacement pointer only moves when the table is full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rr_q <= '0;
    else if (alloc && (&ev_q)) rr_q <= rr_q + 1'b1;
  end

  // ----------------------------------------------------------------------
  // response records and fifo
  // ----------------------------------------------------------------------
  // zero selects auto mode
  wire [5:0]  ewl_app = (ewl_q == 6'h00) ? in_ewl_q : ewl_q;
  wire [31:0] rec_tag = (32'(TSF_K_TAG) << `TSF_REC_KIND) |
                        (32'(ewl_app) << `TSF_REC_EWL) | 32'(in_id_q);
  wire [31:0] rec_sum = (32'(TSF_K_SUM) << `TSF_REC_KIND) |
                        (32'(cnt_q) << `TSF_REC_CNT);
  assign rq.in_valid  = want | (st_q == TSF_SUM);
  assign rq.in_data   = want ? rec_tag : rec_sum;
  assign rq.out_ready = pop;
  tsf_fifo #(.W(32), .DEPTH(FIFO_D)) u_fifo (
    .clk   (pclk),
    .rst_n (presetn),
    .f     (rq.fifo)
  );
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign tag_ready = tag_rdy_q;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_empty_wrap;
    per_wrap && rep_q && omit_q && cnt_q == 8'h00 && !push_tg;
  endsequence
  sequence s_full_wrap;
    per_wrap && cnt_q != 8'h00;
  endsequence
  dflt_sess_a: assert property (go && sess_def_q |=>
    (rep_q ? eff_s == TSF_S2 : eff_s == TSF_S0))
    else $error("default session not applied");
  s0_pass_a: assert property (want && eff_s == TSF_S0 && rq.in_ready
    |=> cnt_q == $past(cnt_q) + 8'h01 || $past(cnt_q) == 8'hFF)
    else $error("S0 tag not reported");
  inv_skip_a: assert property (in_v_q && any_hit && eff_s != TSF_S0
    |-> !push_tg) else $error("inventoried tag reported");
  s1_exp_a: assert property (ms_tick && s1 && !hold && ev_q[0]
    && eage_q[0] >= 13'(S1_MS) && !(alloc && victim == '0) |=> !ev_q[0])
    else $error("S1 flag did not revert");
  s23_rfsh_a: assert property (consume && hv[0] && s23 && !alloc
    |=> eage_q[0] == 13'h0000) else $error("S2/S3 absence not restarted");
  flt_and_a: assert property (push_tg && fmode_q == TSF_F_AND
    |-> f0 && f1) else $error("AND filter let tag through");
  dup_one_a: assert property (push_tg && dup_q |->
    !(any_hit && er_q[hit_i]))
    else $error("duplicate identifier in one response");
  omit_a: assert property (s_empty_wrap |=>
    (st_q != TSF_SUM)[*2]) else $error("empty period not omitted");
  sum_a: assert property ((s_full_wrap and !stop) |=>
    st_q == TSF_SUM ##[0:8] (rq.in_valid && rq.in_data == rec_sum))
    else $error("period summary missing");
  ewl_auto_a: assert property (push_tg && ewl_q == 6'h00
    |-> rq.in_data[`TSF_REC_EWL +: 6] == in_ewl_q)
    else $error("auto length not measured value");
  ewl_rng_a: assert property (ewl_q <= `TSF_EWL_MAX)
    else $error("length setting out of range");
  apb_ans_a: assert property (acc |=> pready_q ##1 !pready_q)
    else $error("apb answer not one wait state");
endmodule : tsf_ctrl
`default_nettype wire

// File: test/tsf_tag_src.sv
// Purpose: tags in the field, offered one report at a time
// Assumes: tag_ready sampled at the pclk rising edge
// Notes:   a released id shows inverted, never a stale copy
`timescale 1ns/100ps
`default_nettype none
module tsf_tag_src (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         go,
  input  wire logic [3:0]   na,
  input  wire logic [3:0]   nb,
  input  wire logic         tag_ready,
  output var  logic         tag_valid,
  output var  logic [15:0]  tag_id,
  output var  logic [5:0]   tag_ewl,
  output var  logic [255:0] tag_mem,
  output var  logic         busy
);
  logic [4:0] left_q;
  wire        is_a = (tag_id == 16'hA1C3);
  // tag a holds AB in bank 1 bits 0..7, tag b does not
  assign tag_ewl = is_a ? 6'h07 : 6'h05;
  assign tag_mem = {128'h0, is_a ? 8'hAB : 8'h3C, 120'h0};
  assign busy    = tag_valid | (left_q != 5'h00);
  // copies of a go first; offer held until taken
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_valid <= 1'b0;
      left_q    <= 5'h00;
      tag_id    <= 16'h0000;
    end else if (go) begin
      left_q <= 5'(na) + 5'(nb);
    end else if (tag_valid && tag_ready) begin
      tag_valid <= 1'b0;
      left_q    <= left_q - 5'h01;
      tag_id    <= ~tag_id;
    end else if (!tag_valid && left_q != 5'h00) begin
      tag_valid <= 1'b1;
      tag_id    <= (left_q > 5'(nb)) ? 16'hA1C3 : 16'h5B20;
    end
  end
endmodule : tsf_tag_src
`default_nettype wire

// File: test/tb.sv
// Purpose: self-checking bench for the tag session and filter control
// Assumes: 1 ms is MS cycles and one period is two ms, shortened for simulation
// Notes:   read results are queued by the driver, checked by a monitor
`timescale 1ns/100ps
`default_nettype none
`include "tsf_map.svh"
module tb;
  localparam int MS = 64;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [3:0] na = 0, nb = 0;
  logic pready, pslverr, tag_ready, tag_valid, busy;
  logic [15:0] tag_id;
  logic [5:0] tag_ewl;
  logic [255:0] tag_mem;
  logic [32:0] q[$];
  int errors = 0, n_compared = 0, seed = 60321;
  always #2 pclk = ~pclk;
  tsf_ctrl #(.MS_CYC(MS)) dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .tag_valid, .tag_ready,
    .tag_id, .tag_ewl, .tag_mem);
  tsf_tag_src src (.pclk, .presetn, .go, .na, .nb, .tag_ready, .tag_valid,
    .tag_id, .tag_ewl, .tag_mem, .busy);
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // monitor: oldest note {error, read data} against each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      n_compared++;
      if ({pslverr, (pwrite ? 32'h0 : prdata)} !== q[0]) begin
        errors++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time,
                 {pslverr, (pwrite ? 32'h0 : prdata)}, q[0]);
      end
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge pclk);
    errors++;
    wrap_up;
  end
  // request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [32:0] e = 33'h0);
    int i;
    q.push_back(e);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
    if (i == 50) begin errors++; wrap_up; end
    {psel, penable} <= 2'b00;
  endtask : apb
  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e});
  endtask : rd
  // one once or repeat run: ea/eb tag records expected, ew fixed length
  task run(input logic [31:0] ss, fm, sm, ct, input logic [3:0] a, b,
           input int ea, eb, input logic [5:0] ew);
    apb(1'b1, `TSF_OFF_SESS, ss);
    apb(1'b1, `TSF_OFF_FMODE, fm);
    apb(1'b1, `TSF_OFF_SMOOTH, sm);
    apb(1'b1, `TSF_OFF_CTRL, ct);
    {na, nb, go} <= {a, b, 1'b1};
    @(posedge pclk) go <= 1'b0;
    // one period of two ms: the free-running ms prescaler makes the first ms short
    repeat (2 * MS + 20) @(posedge pclk);
    repeat (ea) rd(`TSF_OFF_RSP, {2'h1, ew ? ew : 6'h07, 8'h0, 16'hA1C3});
    repeat (eb) rd(`TSF_OFF_RSP, {2'h1, ew ? ew : 6'h05, 8'h0, 16'h5B20});
    if (ct[2]) apb(1'b1, `TSF_OFF_CTRL, 32'h2);
    else rd(`TSF_OFF_RSP, {2'h2, 6'h0, 8'(ea + eb), 16'h0});
    rd(`TSF_OFF_RSP, 32'h0);
    $display("run done session %h mode %h", ss, fm);
  endtask : run
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TSF_OFF_SESS, 32'h4);
    rd(`TSF_OFF_EWL, 32'h0);
    apb(1'b1, `TSF_OFF_EWL, 32'h21, {1'b1, 32'h0});
    rd(`TSF_OFF_EWL, 32'h0);
    apb(1'b0, 8'h3C, 32'h0, {1'b1, 32'h0});
    apb(1'b1, `TSF_OFF_PERIOD, 32'h2);
    apb(1'b1, `TSF_OFF_FLT0, 32'h0008_0001);
    apb(1'b1, `TSF_OFF_FLT1, 32'h0000_0002);
    apb(1'b1, `TSF_OFF_FDAT0, {8'hAB, 24'($random(seed))});
    // S1 first: any earlier read would already mark the tag inventoried
    run(1, 0, 0, 1, 1, 0, 1, 0, 0);
    run(1, 0, 0, 1, 1, 0, 0, 0, 0);
    for (int m = 0; m < 4; m++) begin
      run(0, m, 0, 1, 1, 1, 1, m % 2, 0);
    end
    run(0, 3, 1, 1, 2, 1, 1, 1, 0);
    run(4, 0, 6, 5, 2, 0, 0, 0, 0);
    apb(1'b1, `TSF_OFF_EWL, 32'h20);
    run(0, 0, 0, 1, 1, 0, 1, 0, 6'h20);
    run(4, 0, 4, 5, 0, 0, 0, 0, 0);
    wrap_up;
  end
endmodule : tb
`default_nettype wire
